// *** hdl/adc_conversion_sequencer.sv ***
// Purpose: sequences the multiplexed 10-bit converter over all channels
// Assumes: converter result on conv_data_i is stable when a slot ends
// Notes: settings are latched per measurement; bit 10 of raw is overrange
// Behaviour
// RULE1 - average sixteen conversions per channel, store only the average
// RULE2 - averaging-off bit stores each single conversion directly
// RULE3 - default round-robin pass lasts 146.5 ms
// RULE4 - slot times: voltage 0.7 ms, remote 7 ms, local 1.3 ms
// RULE5 - extended-cycle bit stretches the pass to 240 ms
// RULE6 - bypass-all bit removes attenuators on all five voltage inputs
// RULE7 - per-input bypass bits for 2.5 V, core, 5 V and 12 V
// RULE8 - single-channel bit converts only the selected channel
// RULE9 - single-channel mode reconverts and stores every 0.7 ms; code repeats at the selected channel's slot time plus two cycles
// RULE10 - three-bit select in the fan limit byte picks the channel
// RULE11 - channel select shares storage with the fan limit high byte
// RULE12 - 10-bit result, overrange saturates at 1023
// RULE13 - voltage values live at 0x20 to 0x24, reset to zero
// RULE14 - compare each voltage result with its limits, set status
// RULE15 - setting changes take effect at the next measurement
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int VOLT_CONV_CYCLES = VOLT_CONV_CYCLES_DFLT,
   parameter int REMOTE_CONV_CYCLES = REMOTE_CONV_CYCLES_DFLT,
   parameter int LOCAL_CONV_CYCLES = LOCAL_CONV_CYCLES_DFLT,
   parameter int CYCLE_DEFAULT_CYCLES = CYCLE_DEFAULT_CYCLES_DFLT,
   parameter int CYCLE_EXTENDED_CYCLES = CYCLE_EXTENDED_CYCLES_DFLT
)(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic [RAW_W-1:0] conv_data_i,
   output conv_cmd_t conv_cmd_o,
   output logic [NUM_VOLT-1:0] limit_status_o
);
   localparam logic [CNT_W-1:0] PASS_MAX = '1;

   seq_state_t state_reg, state_next;
   channel_t chan_reg, chan_next;
   logic [3:0] sample_reg, sample_next;
   logic [ACC_W-1:0] acc_reg, acc_next;
   logic [CNT_W-1:0] timer_reg, timer_next;
   logic [CNT_W-1:0] pass_reg, pass_next;
   logic [RES_W-1:0] result_reg, result_next;
   seq_cfg_t lat_reg, lat_next;
   conv_cmd_t cmd_reg, cmd_next;
   logic [7:0] cfg2_reg, cfg2_next;
   logic [7:0] cfg6_reg, cfg6_next;
   logic [7:0] byp_reg, byp_next;
   logic [7:0] fan1_high_reg, fan1_high_next;
   logic [7:0] limit_reg [NUM_LIMIT];
   logic [7:0] limit_next [NUM_LIMIT];
   logic [NUM_VOLT-1:0] status_reg, status_next;
   logic [7:0] other_reg, other_next;
   logic is_value_reg, is_value_next;
   logic rd_pend_reg;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg;
   logic [RES_W-1:0] mem_rdata;
   logic [ACC_W-1:0] sum;
   logic [RES_W-1:0] sat;
   logic avg_bypass;
   logic exceed;
   logic store_wr;
   logic [CNT_W-1:0] pass_target;
   channel_t ch_now;
   logic [NUM_VOLT-1:0] bypass_vec;

   function automatic logic [CNT_W-1:0] conv_load(input channel_t ch);
      logic [CNT_W-1:0] v;
      unique case (ch)
         CH_REMOTE1, CH_REMOTE2: v = CNT_W'(REMOTE_CONV_CYCLES - 1);
         CH_LOCAL: v = CNT_W'(LOCAL_CONV_CYCLES - 1);
         default: v = CNT_W'(VOLT_CONV_CYCLES - 1);
      endcase
      return v;
   endfunction

   // settings seen by the next measurement
   always_comb begin
      // select bits read straight from the fan limit byte, see RULE10 see RULE11
      ch_now = cfg2_reg[CFG2_SINGLE_BIT] ? channel_t'(fan1_high_reg[SEL_MSB:SEL_LSB]) : chan_reg;
      // supply input has no individual bypass, see RULE6 see RULE7
      bypass_vec = {5{cfg2_reg[CFG2_BYPASS_ALL_BIT]}} |
                   {byp_reg[BYP_12V_BIT], byp_reg[BYP_5V_BIT], 1'b0,
                    byp_reg[BYP_CORE_BIT], byp_reg[BYP_2V5_BIT]};
      // single mode never averages, so each slot updates the value, see RULE9
      avg_bypass = lat_reg.avg_off | lat_reg.single;
      // overrange saturates, see RULE12
      sat = conv_data_i[RAW_W-1] ? RESULT_MAX : conv_data_i[RES_W-1:0];
      sum = acc_reg + ACC_W'(sat);
      pass_target = lat_reg.ext ? CNT_W'(CYCLE_EXTENDED_CYCLES) : CNT_W'(CYCLE_DEFAULT_CYCLES);
      store_wr = (state_reg == ST_STORE);
      exceed = (result_reg[RES_W-1:2] > limit_reg[{chan_reg, 1'b1}]) |
               (result_reg[RES_W-1:2] < limit_reg[{chan_reg, 1'b0}]);
   end

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      chan_next = chan_reg;
      sample_next = sample_reg;
      acc_next = acc_reg;
      timer_next = timer_reg;
      result_next = result_reg;
      lat_next = lat_reg;
      cmd_next = cmd_reg;
      cmd_next.start = 1'b0;
      pass_next = (pass_reg == PASS_MAX) ? pass_reg : pass_reg + CNT_W'(1);
      unique case (state_reg)
         ST_START: begin
            // settings captured only here, see RULE15
            lat_next.avg_off = cfg2_reg[CFG2_AVG_OFF_BIT];
            lat_next.single = cfg2_reg[CFG2_SINGLE_BIT]; // see RULE8
            lat_next.ext = cfg6_reg[CFG6_EXT_CYCLE_BIT];
            chan_next = ch_now;
            cmd_next.start = 1'b1;
            cmd_next.channel = ch_now;
            cmd_next.bypass = bypass_vec;
            timer_next = conv_load(ch_now); // see RULE4
            sample_next = 4'h0;
            acc_next = '0;
            state_next = ST_CONVERT;
         end
         ST_CONVERT: begin
            if (timer_reg == '0) begin
               if (avg_bypass) begin
                  result_next = sat; // see RULE2
                  state_next = ST_STORE;
               end else if (sample_reg == AVG_LAST) begin
                  result_next = sum[ACC_W-1:AVG_SHIFT]; // see RULE1
                  state_next = ST_STORE;
               end else begin
                  acc_next = sum;
                  sample_next = sample_reg + 4'h1;
                  timer_next = conv_load(chan_reg);
                  cmd_next.start = 1'b1;
               end
            end else begin
               timer_next = timer_reg - CNT_W'(1);
            end
         end
         ST_STORE: begin
            if (lat_reg.single) begin
               state_next = ST_START;
            end else if (chan_reg == CH_REMOTE2) begin
               state_next = ST_PASS_WAIT;
            end else begin
               chan_next = channel_t'(chan_reg + 3'd1);
               state_next = ST_START;
            end
         end
         ST_PASS_WAIT: begin
            // pad the pass to its cycle time only when averaging, see RULE3 see RULE5
            if (lat_reg.avg_off || pass_reg >= pass_target) begin
               chan_next = CH_2V5;
               pass_next = '0;
               state_next = ST_START;
            end
         end
      endcase
   end

   // register writes, status and read path
   always_comb begin
      cfg2_next = cfg2_reg;
      cfg6_next = cfg6_reg;
      byp_next = byp_reg;
      fan1_high_next = fan1_high_reg;
      for (int i = 0; i < NUM_LIMIT; i++) begin
         limit_next[i] = limit_reg[i];
      end
      status_next = status_reg;
      other_next = READ_ZERO;
      is_value_next = 1'b0;
      rdata_next = rdata_reg;
      if (reg_req_i.wr) begin
         unique case (reg_req_i.addr)
            ADDR_CONFIG_TWO: cfg2_next = reg_req_i.wdata;
            ADDR_CONFIG_SIX: cfg6_next = reg_req_i.wdata;
            ADDR_ATTEN_BYPASS: byp_next = reg_req_i.wdata;
            ADDR_FAN1_MIN_HIGH: fan1_high_next = reg_req_i.wdata; // see RULE11
            default: begin
               if (reg_req_i.addr >= ADDR_LIMIT_BASE && reg_req_i.addr <= ADDR_LIMIT_LAST) begin
                  limit_next[4'(reg_req_i.addr - ADDR_LIMIT_BASE)] = reg_req_i.wdata;
               end
            end
         endcase
      end
      if (reg_req_i.rd) begin
         unique case (reg_req_i.addr)
            ADDR_CONFIG_TWO: other_next = cfg2_reg;
            ADDR_CONFIG_SIX: other_next = cfg6_reg;
            ADDR_ATTEN_BYPASS: other_next = byp_reg;
            ADDR_FAN1_MIN_HIGH: other_next = fan1_high_reg;
            ADDR_LIMIT_STATUS: begin
               other_next = 8'(status_reg);
               status_next = '0; // clear on read
            end
            default: begin
               if (reg_req_i.addr >= ADDR_LIMIT_BASE && reg_req_i.addr <= ADDR_LIMIT_LAST) begin
                  other_next = limit_reg[4'(reg_req_i.addr - ADDR_LIMIT_BASE)];
               end
               is_value_next = (reg_req_i.addr >= ADDR_VALUE_BASE) && (reg_req_i.addr <= ADDR_VALUE_LAST);
            end
         endcase
      end
      // a fresh limit event wins over a same-cycle read clear, see RULE14
      if (store_wr && chan_reg <= CH_12V && exceed) begin
         status_next[chan_reg] = 1'b1;
      end
      if (rd_pend_reg) begin
         rdata_next = is_value_reg ? mem_rdata[RES_W-1:2] : other_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_reg <= ST_START;
         chan_reg <= CH_2V5;
         sample_reg <= 4'h0;
         acc_reg <= '0;
         timer_reg <= '0;
         pass_reg <= '0;
         result_reg <= VALUE_RESET;
         lat_reg <= '0;
         cmd_reg <= '0;
         cfg2_reg <= CFG_RESET;
         cfg6_reg <= CFG_RESET;
         byp_reg <= CFG_RESET;
         fan1_high_reg <= CFG_RESET;
         for (int i = 0; i < NUM_LIMIT; i++) begin
            limit_reg[i] <= i[0] ? LIMIT_HIGH_RESET : LIMIT_LOW_RESET;
         end
         status_reg <= '0;
         other_reg <= READ_ZERO;
         is_value_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rdata_reg <= READ_ZERO;
         rvalid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         chan_reg <= chan_next;
         sample_reg <= sample_next;
         acc_reg <= acc_next;
         timer_reg <= timer_next;
         pass_reg <= pass_next;
         result_reg <= result_next;
         lat_reg <= lat_next;
         cmd_reg <= cmd_next;
         cfg2_reg <= cfg2_next;
         cfg6_reg <= cfg6_next;
         byp_reg <= byp_next;
         fan1_high_reg <= fan1_high_next;
         for (int i = 0; i < NUM_LIMIT; i++) begin
            limit_reg[i] <= limit_next[i];
         end
         status_reg <= status_next;
         other_reg <= other_next;
         is_value_reg <= is_value_next;
         rd_pend_reg <= reg_req_i.rd;
         rdata_reg <= rdata_next;
         rvalid_reg <= rd_pend_reg;
      end
   end

   // results land only in the store cycle, see RULE13 see RULE15
   value_store #(.WIDTH(RES_W), .DEPTH(8), .AW(3)) u_store (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .wr_en_i(store_wr),
      .wr_addr_i(3'(chan_reg)),
      .wr_data_i(result_reg),
      .rd_addr_i(reg_req_i.addr[2:0]),
      .rd_data_o(mem_rdata)
   );

   assign conv_cmd_o = cmd_reg;
   assign reg_rdata_o = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;
   assign limit_status_o = status_reg;

   // checks
   property p_avg_sixteen;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_STORE && !avg_bypass) |-> $past(sample_reg) == AVG_LAST;
   endproperty
   a_avg_sixteen: assert property (p_avg_sixteen) else $error("average stored early"); // see RULE1

   property p_no_avg;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_CONVERT && timer_reg == '0 && lat_reg.avg_off) |=>
         state_reg == ST_STORE && result_reg == $past(sat);
   endproperty
   a_no_avg: assert property (p_no_avg) else $error("single result not stored"); // see RULE2

   property p_pass_default;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_PASS_WAIT && !lat_reg.avg_off && !lat_reg.ext) ##1 state_reg == ST_START |->
         $past(pass_reg) >= CNT_W'(CYCLE_DEFAULT_CYCLES);
   endproperty
   a_pass_default: assert property (p_pass_default) else $error("pass ended early"); // see RULE3

   property p_slot_time;
      @(posedge ref_clk_i) disable iff (reset_i)
      cmd_reg.start |-> timer_reg == conv_load(cmd_reg.channel);
   endproperty
   a_slot_time: assert property (p_slot_time) else $error("wrong slot length"); // see RULE4

   property p_pass_ext;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_PASS_WAIT && !lat_reg.avg_off && lat_reg.ext) ##1 state_reg == ST_START |->
         $past(pass_reg) >= CNT_W'(CYCLE_EXTENDED_CYCLES);
   endproperty
   a_pass_ext: assert property (p_pass_ext) else $error("extended pass ended early"); // see RULE5

   property p_bypass_all;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_START && cfg2_reg[CFG2_BYPASS_ALL_BIT]) |=> cmd_reg.bypass == '1;
   endproperty
   a_bypass_all: assert property (p_bypass_all) else $error("attenuator left in"); // see RULE6

   property p_single_sel;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_START && cfg2_reg[CFG2_SINGLE_BIT]) |=>
         cmd_reg.channel == channel_t'($past(fan1_high_reg[SEL_MSB:SEL_LSB])) ##1 state_reg == ST_CONVERT;
   endproperty
   a_single_sel: assert property (p_single_sel) else $error("wrong single channel"); // see RULE8

   property p_saturate;
      @(posedge ref_clk_i) disable iff (reset_i)
      (state_reg == ST_CONVERT && timer_reg == '0 && avg_bypass && conv_data_i[RAW_W-1]) |=>
         result_reg == RESULT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("overrange not saturated"); // see RULE12

   property p_status_set;
      @(posedge ref_clk_i) disable iff (reset_i)
      (store_wr && chan_reg <= CH_12V && exceed) |=> status_reg[$past(chan_reg)];
   endproperty
   a_status_set: assert property (p_status_set) else $error("limit status missed"); // see RULE14
endmodule

// *** hdl/value_store.sv ***
// Purpose: per-channel result storage, one word per channel
// Assumes: one write and one read port, same clock
// Notes: read data is registered, one cycle after the address
module value_store
   import adc_seq_pkg::*;
#(
   parameter int WIDTH = RES_W,
   parameter int DEPTH = 8,
   parameter int AW = 3
)(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [WIDTH-1:0] rd_reg;
   logic [WIDTH-1:0] rd_next;

   // whole word written at once, so a reader never sees half an update
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en_i) begin
         mem_next[wr_addr_i] = wr_data_i;
      end
      rd_next = mem_reg[rd_addr_i];
   end

   // cleared on reset, see RULE13
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= VALUE_RESET;
         end
         rd_reg <= VALUE_RESET;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= mem_next[i];
         end
         rd_reg <= rd_next;
      end
   end

   assign rd_data_o = rd_reg;
endmodule

// *** inc/adc_seq_pkg.sv ***
// Purpose: shared constants and types for the conversion sequencer
// Assumes: 50 MHz reference clock
// Notes: times are held in ns and turned into cycle counts here
package adc_seq_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int VOLT_CONV_TIME_NS = 700000;
   localparam int REMOTE_CONV_TIME_NS = 7000000;
   localparam int LOCAL_CONV_TIME_NS = 1300000;
   localparam int CYCLE_DEFAULT_TIME_NS = 146500000;
   localparam int CYCLE_EXTENDED_TIME_NS = 240000000;
   // least times, so round up to whole cycles
   localparam int VOLT_CONV_CYCLES_DFLT = (VOLT_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REMOTE_CONV_CYCLES_DFLT = (REMOTE_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCAL_CONV_CYCLES_DFLT = (LOCAL_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_DEFAULT_CYCLES_DFLT = (CYCLE_DEFAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_EXTENDED_CYCLES_DFLT = (CYCLE_EXTENDED_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   localparam int RAW_W = 11;
   localparam int RES_W = 10;
   localparam int ACC_W = 14;
   localparam int NUM_VOLT = 5;
   localparam int NUM_LIMIT = 10;
   localparam logic [3:0] AVG_LAST = 4'hf;
   localparam int AVG_SHIFT = 4;
   localparam logic [RES_W-1:0] RESULT_MAX = 10'h3ff;
   localparam logic [RES_W-1:0] VALUE_RESET = 10'h000;
   // register addresses
   localparam logic [7:0] ADDR_CONFIG_SIX = 8'h10;
   localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
   localparam logic [7:0] ADDR_VALUE_LAST = 8'h27;
   localparam logic [7:0] ADDR_LIMIT_STATUS = 8'h41;
   localparam logic [7:0] ADDR_LIMIT_BASE = 8'h44;
   localparam logic [7:0] ADDR_LIMIT_LAST = 8'h4d;
   localparam logic [7:0] ADDR_FAN1_MIN_HIGH = 8'h55;
   localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
   localparam logic [7:0] ADDR_ATTEN_BYPASS = 8'h7d;
   // field positions
   localparam int CFG2_AVG_OFF_BIT = 4;
   localparam int CFG2_BYPASS_ALL_BIT = 5;
   localparam int CFG2_SINGLE_BIT = 6;
   localparam int CFG6_EXT_CYCLE_BIT = 7;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;
   localparam int BYP_2V5_BIT = 4;
   localparam int BYP_CORE_BIT = 5;
   localparam int BYP_5V_BIT = 6;
   localparam int BYP_12V_BIT = 7;
   // reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] LIMIT_LOW_RESET = 8'h00;
   localparam logic [7:0] LIMIT_HIGH_RESET = 8'hff;
   localparam logic [7:0] READ_ZERO = 8'h00;

   typedef enum logic [2:0] {
      CH_2V5, CH_CORE, CH_SUPPLY, CH_5V, CH_12V, CH_REMOTE1, CH_LOCAL, CH_REMOTE2
   } channel_t;

   typedef enum logic [1:0] {ST_START, ST_CONVERT, ST_STORE, ST_PASS_WAIT} seq_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic start;
      channel_t channel;
      logic [NUM_VOLT-1:0] bypass;
   } conv_cmd_t;

   typedef struct packed {
      logic avg_off;
      logic single;
      logic ext;
   } seq_cfg_t;
endpackage

// *** verif/tb.sv ***
// Purpose: self-checking bench for the conversion sequencer
// Assumes: short slot and pass counts set through parameters
// Notes: converter data comes from a fixed seed; only one high limit is driven
module tb
   import adc_seq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int VN = 8;
   localparam int RN = 20;
   localparam int LN = 12;
   localparam int DEF = 2000;
   localparam int EXT = 3000;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   reg_req_t reg_req_i = '0;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [RAW_W-1:0] conv_data_i = '0;
   conv_cmd_t conv_cmd_o;
   logic [NUM_VOLT-1:0] limit_status_o;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int cyc = 0, last_start = 0, gap = 0, run = 0, last_run = 0, pass_mark = 0, pass_gap = 0, pass_cnt = 0;
   logic [2:0] prev_ch = 3'h0;
   logic vary = 1'b0;
   logic [RAW_W-1:0] base = '0, fixed = '0;

   adc_conversion_sequencer #(.VOLT_CONV_CYCLES(VN), .REMOTE_CONV_CYCLES(RN), .LOCAL_CONV_CYCLES(LN),
      .CYCLE_DEFAULT_CYCLES(DEF), .CYCLE_EXTENDED_CYCLES(EXT)) i_adc_conversion_sequencer (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .conv_data_i(conv_data_i), .conv_cmd_o(conv_cmd_o),
      .limit_status_o(limit_status_o));

   // 50 MHz clock
   always #10 ref_clk_i = ~ref_clk_i;

   // slot monitor: gaps, runs per channel and pass period
   // falling edge, so the start launched at the rising edge has settled
   always @(negedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (!reset_i && conv_cmd_o.start === 1'b1) begin
         gap <= cyc - last_start;
         last_start <= cyc;
         prev_ch <= conv_cmd_o.channel;
         if (conv_cmd_o.channel != prev_ch) begin
            last_run <= run;
            run <= 1;
            if (conv_cmd_o.channel == CH_2V5) begin
               pass_gap <= cyc - pass_mark;
               pass_mark <= cyc;
               pass_cnt <= pass_cnt + 1;
            end
         end else begin
            run <= run + 1;
         end
      end
   end

   // converter data: a ramp per run in the averaging test, else a fixed word
   always @(negedge ref_clk_i) conv_data_i <= vary ? base + RAW_W'(run - 1) : fixed;

   // hang guard, well above the expected run length
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         chk("cycle limit", 16'h0, 16'h1);
         end_of_test();
      end
   end

   function automatic logic [7:0] exp_val(input logic [RAW_W-1:0] raw);
      exp_val = raw[10] ? 8'hff : raw[9:2];
   endfunction

   // supply input has no own bypass bit, only the global one
   function automatic logic [4:0] exp_byp(input logic all, input logic [3:0] nib);
      exp_byp = all ? 5'h1f : {nib[3], nib[2], 1'b0, nib[1], nib[0]};
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_req_i <= '{1'b1, 1'b0, a, d};
      @(negedge ref_clk_i);
      reg_req_i <= '0;
   endtask

   // read, answer expected one edge after the request edge
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      int i;
      logic got;
      got = 1'b0;
      @(negedge ref_clk_i);
      reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge ref_clk_i);
      reg_req_i <= '0;
      for (i = 0; i < 4 && !got; i++) begin
         @(posedge ref_clk_i);
         #1;
         if (reg_rvalid_o === 1'b1) begin
            got = 1'b1;
            chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata_o});
         end
      end
      if (!got) chk($sformatf("answer %h", a), 16'h1, 16'h0);
   endtask

   task automatic wait_start(input int n);
      int k, t;
      k = 0;
      t = 0;
      while (k < n && t < 300) begin
         @(posedge ref_clk_i);
         #1;
         t++;
         if (conv_cmd_o.start === 1'b1) k++;
      end
      if (k < n) chk("start pulse", 16'h1, 16'h0);
   endtask

   task automatic wait_pass();
      int p, t;
      p = pass_cnt;
      t = 0;
      while (pass_cnt == p && t < 4000) begin
         @(posedge ref_clk_i);
         #1;
         t++;
      end
      if (pass_cnt == p) chk("pass edge", 16'h1, 16'h0);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      int i, t;
      logic [2:0] sel;
      logic [7:0] fan;
      logic [3:0] nib;
      logic all;
      int n;
      void'($urandom(32'hcbf2f7e9));
      repeat (10) @(negedge ref_clk_i);
      reset_i <= 1'b0;
      // reset values, and an unmapped place
      for (i = 0; i < 8; i++) rchk(ADDR_VALUE_BASE + 8'(i), 8'h00);
      rchk(ADDR_CONFIG_TWO, 8'h00);
      rchk(ADDR_CONFIG_SIX, 8'h00);
      rchk(ADDR_ATTEN_BYPASS, 8'h00);
      rchk(ADDR_FAN1_MIN_HIGH, 8'h00);
      rchk(ADDR_LIMIT_BASE + 8'h01, 8'hff);
      rchk(8'h00, 8'h00);
      $display("test reset done");
      // single channel, averaging off, every select code, random bypass
      for (i = 0; i < 12; i++) begin
         sel = (i < 8) ? 3'(i) : 3'($urandom_range(4, 0));
         fixed = RAW_W'($urandom);
         if (i == 1) fixed = 11'h3ff;
         if (i == 2) fixed[10] = 1'b1;
         nib = 4'($urandom);
         all = (i == 0) ? 1'b1 : ((i == 1) ? 1'b0 : 1'($urandom));
         fan = {sel, 5'($urandom)};
         wr(ADDR_ATTEN_BYPASS, {nib, 4'h0});
         wr(ADDR_CONFIG_TWO, {1'b0, 1'b1, all, 1'b1, 4'h0});
         wr(ADDR_FAN1_MIN_HIGH, fan);
         // first pass lets the averaged measurement in flight drain, up to 15 old slots
         wait_start((i == 0) ? 18 : 3);
         chk("channel", {13'h0, sel}, {13'h0, 3'(conv_cmd_o.channel)});
         if (sel < 3'd5) chk("bypass", {11'h0, exp_byp(all, nib)}, {11'h0, conv_cmd_o.bypass});
         @(posedge ref_clk_i);
         #1;
         n = ((sel < 3'd5) ? VN : ((sel == 3'd6) ? LN : RN)) + 2;
         chk("slot period", 16'(n), 16'(gap));
         rchk(ADDR_VALUE_BASE + {5'h0, sel}, exp_val(fixed));
         rchk(ADDR_FAN1_MIN_HIGH, fan);
      end
      // a high limit under the value sets the sticky flag of that input only
      fixed = 11'h200;
      wr(ADDR_LIMIT_BASE + {4'h0, sel, 1'b1}, 8'h7f);
      wait_start(3);
      @(posedge ref_clk_i);
      #1;
      chk("limit flags", 16'(5'h1 << sel), {11'h0, limit_status_o});
      rchk(ADDR_LIMIT_STATUS, 8'(5'h1 << sel));
      $display("test single channel done");
      // averaging on, round robin, ramp across the 16 samples
      fixed = '0;
      base = RAW_W'($urandom_range(1008, 0));
      vary = 1'b1;
      wr(ADDR_CONFIG_TWO, 8'h00);
      wait_pass();
      t = 0;
      while (!(conv_cmd_o.start === 1'b1 && conv_cmd_o.channel == CH_CORE) && t < 3000) begin
         @(posedge ref_clk_i);
         #1;
         t++;
      end
      @(posedge ref_clk_i);
      #1;
      chk("samples per value", 16'd16, 16'(last_run));
      rchk(ADDR_VALUE_BASE, 8'((base + 11'd7) >> 2));
      vary = 1'b0;
      $display("test averaging done");
      // pass period, default then extended
      wait_pass();
      wait_pass();
      chk("default pass", 16'h1, 16'(pass_gap >= DEF && pass_gap <= DEF + 4));
      wr(ADDR_CONFIG_SIX, 8'h80);
      wait_pass();
      wait_pass();
      chk("extended pass", 16'h1, 16'(pass_gap >= EXT && pass_gap <= EXT + 4));
      // averaging off: no padding, the next pass follows at once
      wr(ADDR_CONFIG_TWO, 8'h10);
      wait_pass();
      wait_pass();
      chk("unpadded pass", 16'(5 * (VN + 2) + 2 * RN + LN + 7), 16'(pass_gap));
      $display("test pass period done");
      end_of_test();
   end
endmodule
